// ===== logic/mdrv_regs.sv
// Register bank, reset classes, setpoint conditioning and sled PWM latch
// of a six-channel motor driver.
// Assumes the host frames the serial link with an active-low select and
// that analog level indications arrive asynchronously on pins.
`timescale 1ns/100ps
`include "mdrv_map.svh"

// Behaviour
// - Hard reset or control command clears mode registers.
// - Hard reset or setpoint command clears setpoints.
// - Frame, timeout and load fault flags latch until hard, control or individual reset.
// - Individual clear commands clear only their flag.
// - Undervoltage flag cleared only by deep undervoltage or standby.
// - Reset command bits clear themselves after acting.
// - Overtemperature flag follows input, hard reset only.
// - Summary bit is OR of flags four..zero.
// - Setpoints are 12-bit two's-complement words.
// - Focus and tracking gain bit selects gain.
// - Loading gain bit low selects low gain.
// - Sled uses upper ten bits, low bits zero.
// - Sled drive zero from FE4h through 01Ch.
// - Spindle drive zero from FECh through 014h.
// - Sled on at PWM edge, off at limit.
module mdrv_regs #(
    parameter logic [13:0] WDT_LONG_CYC = 14'(`MDRV_WDT_LONG_CYC)
) (
    // Main clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Serial link from the host.
    input wire logic sclk_in,
    input wire logic slv_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // Analog level indications.
    input wire logic predriver_supply_low_in,
    input wire logic predriver_supply_deep_low_in,
    input wire logic internal_regulator_supply_low_in,
    input wire logic internal_regulator_supply_deep_low_in,
    input wire logic standby_input_n_in,
    input wire logic overtemp_in,
    input wire logic load_short_in,
    // Sled PWM clock and current comparators.
    input wire logic pwm_clk_in,
    input wire logic [1:0] sled_limit_in,
    // Drive levels and controls.
    output logic [11:0] focus_level_out,
    output logic [11:0] tracking_level_out,
    output logic [11:0] spindle_level_out,
    output logic [11:0] loading_level_out,
    output logic [9:0] sled_one_level_out,
    output logic [9:0] sled_two_level_out,
    output logic [1:0] sled_on_out,
    output logic [2:0] gain_high_out,
    output logic spindle_reverse_brake_out,
    output logic load_short_brake_out,
    output logic [7:0] channel_enable_out,
    output logic [7:0] power_active_out,
    output logic fault_summary_out
);

    ////////////////////////////////////////////////////////////////////////
    // Main clock domain.

    mdrv_pkg::mdrv_core_t c_ff;
    mdrv_pkg::mdrv_core_t nxt_c;
    mdrv_pkg::mdrv_link_t l_ff;
    mdrv_pkg::mdrv_link_t nxt_l;
    mdrv_pkg::mdrv_rst_req_t req;
    mdrv_pkg::mdrv_pins_t pins;
    logic fresh_ff;

    // Pins gathered for the two-stage synchroniser.
    assign pins = {slv_n_in, predriver_supply_low_in,
        predriver_supply_deep_low_in, internal_regulator_supply_low_in,
        internal_regulator_supply_deep_low_in, standby_input_n_in,
        overtemp_in, load_short_in, pwm_clk_in, sled_limit_in};

    // Hard reset requests come only from the second synchroniser stage.
    always_comb begin
        req.hard = c_ff.s2.puv | c_ff.s2.ruv | ~c_ff.s2.stby_n;
        req.deep = c_ff.s2.pduv | c_ff.s2.rduv | ~c_ff.s2.stby_n;
    end

    // Next state of the main domain.
    always_comb begin
        logic frame_end;
        logic [7:0] wd;
        logic is_ctrl;
        logic do_wr;
        logic [13:0] wdt_lim;
        logic [11:0] sl;
        logic dz;
        frame_end = 1'b0;
        wd = 8'h00;
        is_ctrl = 1'b0;
        do_wr = 1'b0;
        wdt_lim = 14'h0000;
        sl = 12'h000;
        dz = 1'b0;
        nxt_c = c_ff;
        nxt_c.s1 = pins;
        nxt_c.s2 = c_ff.s1;
        nxt_c.slv_prev = c_ff.s2.slv_n;
        nxt_c.pwm_prev = c_ff.s2.pwm;

        // Link words are stable once select has risen: the link clock
        // stops outside frames, so no gray coding is needed here.
        frame_end = c_ff.s2.slv_n & ~c_ff.slv_prev;
        wd = l_ff.sh[7:0];
        is_ctrl = l_ff.sh[15] & l_ff.sh[14];
        do_wr = frame_end && (l_ff.cnt == `MDRV_FRAME_BITS);

        // Commands act one cycle after they were written, then vanish.
        nxt_c.cmd = `MDRV_RST_BYTE;

        // Register writes from a complete frame.
        if (do_wr && is_ctrl && !l_ff.sh[8]) begin
            case (l_ff.sh[15:9])
                `MDRV_REG_OUT_EN: nxt_c.out_en = wd & `MDRV_MASK_CHAN;
                `MDRV_REG_PSAVE: nxt_c.psave = wd & `MDRV_MASK_CHAN;
                `MDRV_REG_DRV_SET: nxt_c.drv_set = wd & `MDRV_MASK_CHAN;
                `MDRV_REG_PKT_TIME: nxt_c.pkt_time = wd & `MDRV_MASK_PKT_TIME;
                `MDRV_REG_RESET: nxt_c.cmd = wd & `MDRV_MASK_RESET;
                `MDRV_REG_RST_CHECK: nxt_c.chk = wd & `MDRV_MASK_RST_CHECK;
                default: ;
            endcase
        end else if (do_wr && !is_ctrl) begin
            // Setpoints are kept as two's-complement words; sled words drop their two low bits.
            case (l_ff.sh[15:12])
                `MDRV_IDX_FOCUS: nxt_c.setp.focus = l_ff.sh[11:0];
                `MDRV_IDX_TRACKING: nxt_c.setp.tracking = l_ff.sh[11:0];
                `MDRV_IDX_SLED_ONE: begin
                    nxt_c.setp.sled1 = {l_ff.sh[11:2], 2'b00};
                end
                `MDRV_IDX_SLED_TWO: begin
                    nxt_c.setp.sled2 = {l_ff.sh[11:2], 2'b00};
                end
                `MDRV_IDX_SPINDLE: nxt_c.setp.spindle = l_ff.sh[11:0];
                `MDRV_IDX_LOADING: nxt_c.setp.loading = l_ff.sh[11:0];
                default: ;
            endcase
        end

        // Mode class clear; setpoint class untouched by it.
        if (req.hard || c_ff.cmd[`MDRV_CMD_CTRL]) begin
            nxt_c.out_en = `MDRV_RST_BYTE;
            nxt_c.psave = `MDRV_RST_BYTE;
            nxt_c.drv_set = `MDRV_RST_BYTE;
            nxt_c.pkt_time = `MDRV_RST_BYTE;
            nxt_c.chk[`MDRV_CHK_MODE] = 1'b0;
        end
        // Setpoint class clear; mode class untouched by it.
        if (req.hard || c_ff.cmd[`MDRV_CMD_SETP]) begin
            nxt_c.setp = '0;
            nxt_c.chk[`MDRV_CHK_SETP] = 1'b0;
        end

        // Packet watchdog: restarts on every frame end, off in mode 00/01.
        case (c_ff.pkt_time[5:4])
            2'b10: wdt_lim = WDT_LONG_CYC;
            2'b11: wdt_lim = 14'(`MDRV_WDT_SHORT_CYC);
            default: wdt_lim = 14'h0000;
        endcase
        if (frame_end || wdt_lim == 14'h0000) begin
            nxt_c.wdt = 14'h0000;
        end else if (c_ff.wdt != wdt_lim) begin
            nxt_c.wdt = c_ff.wdt + 14'h0001;
        end

        // Latched flags: a new event beats any software clear.
        if (c_ff.cmd[`MDRV_CMD_CTRL] || c_ff.cmd[`MDRV_CMD_FCERR]) begin
            nxt_c.fcerr = 1'b0;
        end
        if (c_ff.cmd[`MDRV_CMD_CTRL] || c_ff.cmd[`MDRV_CMD_FTO]) begin
            nxt_c.fto = 1'b0;
        end
        if (c_ff.cmd[`MDRV_CMD_CTRL] || c_ff.cmd[`MDRV_CMD_LFLT]) begin
            nxt_c.lflt = 1'b0;
        end
        if (frame_end && l_ff.cnt != `MDRV_FRAME_BITS) begin
            nxt_c.fcerr = 1'b1;
        end
        if (wdt_lim != 14'h0000 && c_ff.wdt == wdt_lim - 14'h0001) begin
            nxt_c.fto = 1'b1;
        end
        if (c_ff.s2.lshort) begin
            nxt_c.lflt = 1'b1;
        end
        if (req.hard) begin
            nxt_c.fcerr = 1'b0;
            nxt_c.fto = 1'b0;
            nxt_c.lflt = 1'b0;
        end

        // Undervoltage flag sticks until the supply falls much further or standby is asserted.
        if (req.deep) begin
            nxt_c.uv = 1'b0;
        end else if (c_ff.s2.puv || c_ff.s2.ruv) begin
            nxt_c.uv = 1'b1;
        end
        nxt_c.ot = c_ff.s2.ot & ~req.hard;
        nxt_c.summary = |{nxt_c.lflt, nxt_c.ot, nxt_c.fcerr,
                          nxt_c.fto, nxt_c.uv};

        // Freeze the readback image while a frame is in progress.
        if (c_ff.s2.slv_n) begin
            nxt_c.image = {c_ff.out_en, c_ff.psave, c_ff.drv_set,
                c_ff.pkt_time, c_ff.summary, 2'b00, c_ff.lflt, c_ff.ot,
                c_ff.fcerr, c_ff.fto, c_ff.uv, c_ff.chk};
        end

        // Channel enables drop while any all-off fault stands.
        nxt_c.chan_en = c_ff.out_en;
        if (req.hard || c_ff.ot || c_ff.uv || c_ff.fto) begin
            nxt_c.chan_en = `MDRV_RST_BYTE;
        end
        if (c_ff.lflt) begin
            nxt_c.chan_en[`MDRV_CH_LD] = 1'b0;
        end

        // Drive levels; gain selection travels beside them.
        nxt_c.lvl.focus = c_ff.setp.focus;
        nxt_c.lvl.tracking = c_ff.setp.tracking;
        nxt_c.lvl.loading = c_ff.setp.loading;
        dz = ($signed(c_ff.setp.spindle) >= $signed(`MDRV_SPIN_DZ_LO)) &&
             ($signed(c_ff.setp.spindle) <= $signed(`MDRV_SPIN_DZ_HI));
        nxt_c.lvl.spindle = dz ? 12'h000 : c_ff.setp.spindle;

        // Sled channels: dead zone, then the PWM set/reset latch.
        for (int i = 0; i < 2; i++) begin
            sl = (i == 0) ? c_ff.setp.sled1 : c_ff.setp.sled2;
            dz = ($signed(sl) >= $signed(`MDRV_SLED_DZ_LO)) &&
                 ($signed(sl) <= $signed(`MDRV_SLED_DZ_HI));
            if (dz) begin
                sl = 12'h000;
            end
            if (i == 0) begin
                nxt_c.lvl.sled1 = sl;
            end else begin
                nxt_c.lvl.sled2 = sl;
            end
            if (dz || !c_ff.chan_en[`MDRV_CH_SL]) begin
                nxt_c.sled_on[i] = 1'b0;
            end else if (c_ff.s2.pwm && !c_ff.pwm_prev) begin
                nxt_c.sled_on[i] = 1'b1;
            end else if (c_ff.s2.lim[i]) begin
                nxt_c.sled_on[i] = 1'b0;
            end
        end
    end

    // Main domain register.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            c_ff <= '0;
            c_ff.s1.slv_n <= 1'b1;
            c_ff.s2.slv_n <= 1'b1;
            c_ff.slv_prev <= 1'b1;
            c_ff.s1.stby_n <= 1'b1;
            c_ff.s2.stby_n <= 1'b1;
        end else begin
            c_ff <= nxt_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain.

    // Marks the first link clock of a frame; preset while select is high.
    always_ff @(posedge sclk_in or posedge slv_n_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fresh_ff <= 1'b1;
        end else if (slv_n_in) begin
            fresh_ff <= 1'b1;
        end else begin
            fresh_ff <= 1'b0;
        end
    end

    // Shift in, count bits, and pick the readback byte after the header.
    always_comb begin
        logic [7:0] rb;
        rb = 8'h00;
        nxt_l = l_ff;
        nxt_l.sh = {l_ff.sh[14:0], sdi_in};
        if (fresh_ff) begin
            nxt_l.cnt = 5'h01;
        end else if (l_ff.cnt != 5'h1f) begin
            nxt_l.cnt = l_ff.cnt + 5'h01;
        end
        case (nxt_l.sh[7:1])
            `MDRV_REG_OUT_EN: rb = c_ff.image.out_en;
            `MDRV_REG_PSAVE: rb = c_ff.image.psave;
            `MDRV_REG_DRV_SET: rb = c_ff.image.drv_set;
            `MDRV_REG_PKT_TIME: rb = c_ff.image.pkt_time;
            `MDRV_REG_STATUS: rb = c_ff.image.status;
            `MDRV_REG_RST_CHECK: rb = c_ff.image.chk;
            default: rb = 8'h00;
        endcase
        if (nxt_l.cnt == `MDRV_HDR_BITS) begin
            nxt_l.rd = rb;
            nxt_l.rd_act = nxt_l.sh[0] & nxt_l.sh[7] & nxt_l.sh[6];
        end else if (nxt_l.cnt == `MDRV_FRAME_BITS) begin
            nxt_l.rd_act = 1'b0;
            nxt_l.rd = {l_ff.rd[6:0], 1'b0};
        end else if (l_ff.rd_act) begin
            nxt_l.rd = {l_ff.rd[6:0], 1'b0};
        end
        if (fresh_ff) begin
            nxt_l.rd_act = 1'b0;
        end
    end

    // Link domain register.
    always_ff @(posedge sclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            l_ff <= '0;
        end else begin
            l_ff <= nxt_l;
        end
    end

    // Serial output changes on the falling edge, released by select.
    always_ff @(negedge sclk_in or posedge slv_n_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sdo_out <= 1'b0;
            sdo_oe_out <= 1'b0;
        end else if (slv_n_in) begin
            sdo_oe_out <= 1'b0;
            sdo_out <= 1'b0;
        end else begin
            sdo_out <= l_ff.rd[7];
            sdo_oe_out <= l_ff.rd_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all taken from main domain flops.

    assign focus_level_out = c_ff.lvl.focus;
    assign tracking_level_out = c_ff.lvl.tracking;
    assign spindle_level_out = c_ff.lvl.spindle;
    assign loading_level_out = c_ff.lvl.loading;
    assign sled_one_level_out = c_ff.lvl.sled1[11:2];
    assign sled_two_level_out = c_ff.lvl.sled2[11:2];
    assign sled_on_out = c_ff.sled_on;
    // Bit 2 focus, bit 1 tracking, bit 0 loading; zero means low gain.
    assign gain_high_out = {c_ff.drv_set[`MDRV_DRV_GAIN_FC],
                            c_ff.drv_set[`MDRV_DRV_GAIN_TK],
                            c_ff.drv_set[`MDRV_DRV_GAIN_LD]};
    assign spindle_reverse_brake_out = c_ff.drv_set[`MDRV_DRV_SP_BRAKE];
    assign load_short_brake_out = c_ff.drv_set[`MDRV_DRV_LD_BRAKE];
    assign channel_enable_out = c_ff.chan_en;
    assign power_active_out = c_ff.psave;
    assign fault_summary_out = c_ff.summary;

endmodule : mdrv_regs

// ===== logic/mdrv_map.svh
// Register offsets, field positions, reset values and timing counts
// for the motor driver register bank.
// Assumes inclusion by bare name.
`ifndef MDRV_MAP_SVH
`define MDRV_MAP_SVH
// Setpoint indices in the 4-bit frame field.
`define MDRV_IDX_FOCUS 4'h2
`define MDRV_IDX_TRACKING 4'h3
`define MDRV_IDX_SLED_ONE 4'h4
`define MDRV_IDX_SLED_TWO 4'h5
`define MDRV_IDX_SPINDLE 4'h8
`define MDRV_IDX_LOADING 4'h9
// Control register addresses.
`define MDRV_REG_OUT_EN 7'h70
`define MDRV_REG_PSAVE 7'h72
`define MDRV_REG_DRV_SET 7'h74
`define MDRV_REG_RESET 7'h75
`define MDRV_REG_PKT_TIME 7'h76
`define MDRV_REG_STATUS 7'h77
`define MDRV_REG_RST_CHECK 7'h7b
// Writable bit masks; other bits read as zero.
`define MDRV_MASK_CHAN 8'h76
`define MDRV_MASK_PKT_TIME 8'h30
`define MDRV_MASK_RST_CHECK 8'hc0
`define MDRV_MASK_RESET 8'hf4
// Reset command bit positions.
`define MDRV_CMD_SETP 7
`define MDRV_CMD_CTRL 6
`define MDRV_CMD_FCERR 5
`define MDRV_CMD_FTO 4
`define MDRV_CMD_LFLT 2
// Driver mode bit positions.
`define MDRV_DRV_SP_BRAKE 6
`define MDRV_DRV_GAIN_FC 5
`define MDRV_DRV_GAIN_TK 4
`define MDRV_DRV_LD_BRAKE 2
`define MDRV_DRV_GAIN_LD 1
// Check flag bit positions.
`define MDRV_CHK_MODE 7
`define MDRV_CHK_SETP 6
// Channel enable bit positions for the sled and loading channels.
`define MDRV_CH_SL 4
`define MDRV_CH_LD 1
// Reset values.
`define MDRV_RST_BYTE 8'h00
`define MDRV_RST_SETP 12'h000
// Dead zone limits, inclusive.
`define MDRV_SLED_DZ_LO 12'hfe4
`define MDRV_SLED_DZ_HI 12'h01c
`define MDRV_SPIN_DZ_LO 12'hfec
`define MDRV_SPIN_DZ_HI 12'h014
// Frame layout.
`define MDRV_FRAME_BITS 5'h10
`define MDRV_HDR_BITS 5'h08
// Packet watchdog spans in main clock cycles at 100 MHz.
`define MDRV_WDT_LONG_CYC 10000
`define MDRV_WDT_SHORT_CYC 3000
`endif

// ===== logic/mdrv_pkg.sv
// Types shared by the motor driver register bank.
// Assumes the map header for all numeric constants.
package mdrv_pkg;
    // Synchronised pin levels.
    typedef struct packed {
        logic slv_n;
        logic puv;
        logic pduv;
        logic ruv;
        logic rduv;
        logic stby_n;
        logic ot;
        logic lshort;
        logic pwm;
        logic [1:0] lim;
    } mdrv_pins_t;
    // Hard reset requests.
    typedef struct packed {
        logic hard;
        logic deep;
    } mdrv_rst_req_t;
    // Setpoint words.
    typedef struct packed {
        logic [11:0] focus;
        logic [11:0] tracking;
        logic [11:0] sled1;
        logic [11:0] sled2;
        logic [11:0] spindle;
        logic [11:0] loading;
    } mdrv_setp_t;
    // Readback bytes frozen during frames.
    typedef struct packed {
        logic [7:0] out_en;
        logic [7:0] psave;
        logic [7:0] drv_set;
        logic [7:0] pkt_time;
        logic [7:0] status;
        logic [7:0] chk;
    } mdrv_image_t;
    // Main clock state.
    typedef struct packed {
        mdrv_pins_t s1;
        mdrv_pins_t s2;
        logic slv_prev;
        logic pwm_prev;
        logic [7:0] out_en;
        logic [7:0] psave;
        logic [7:0] drv_set;
        logic [7:0] pkt_time;
        logic [7:0] chk;
        logic [7:0] cmd;
        mdrv_setp_t setp;
        logic fcerr;
        logic fto;
        logic lflt;
        logic uv;
        logic ot;
        logic [13:0] wdt;
        mdrv_image_t image;
        mdrv_setp_t lvl;
        logic [1:0] sled_on;
        logic [7:0] chan_en;
        logic summary;
    } mdrv_core_t;
    // Serial clock state.
    typedef struct packed {
        logic [15:0] sh;
        logic [4:0] cnt;
        logic [7:0] rd;
        logic rd_act;
    } mdrv_link_t;
endpackage : mdrv_pkg

// ===== tb/mdrv_regs_chk.sv
// Port checker for the motor driver register bank.
// Assumes level inputs change away from the rising main clock edge.
`timescale 1ns/100ps
module mdrv_regs_chk #(
    parameter logic [13:0] WDT_LONG_CYC = 14'h2710
) (
    // Main clock and reset.
    input logic clk_in,
    input logic rst_b_in,
    // Level inputs.
    input logic predriver_supply_low_in,
    input logic internal_regulator_supply_low_in,
    input logic standby_input_n_in,
    input logic overtemp_in,
    input logic pwm_clk_in,
    input logic [1:0] sled_limit_in,
    // Outputs.
    input logic [11:0] focus_level_out,
    input logic [11:0] spindle_level_out,
    input logic [11:0] loading_level_out,
    input logic [9:0] sled_one_level_out,
    input logic [1:0] sled_on_out,
    input logic [2:0] gain_high_out,
    input logic [7:0] channel_enable_out,
    input logic [7:0] power_active_out,
    input logic fault_summary_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////
    // Levels held long enough to cross both synchronisers and a register.
    sequence s_hot;
        overtemp_in [*6];
    endsequence
    sequence s_at_limit;
        (sled_limit_in[0] && !pwm_clk_in) [*6];
    endsequence
    // Hard resets land within four edges.
    chk_first_zero: assert property (
        $rose(rst_b_in) |-> channel_enable_out == 8'h00 && !fault_summary_out)
        else $error("output active at reset release");
    chk_standby_clear: assert property (
        $fell(standby_input_n_in) |-> ##[2:4]
        (focus_level_out == 12'h000 && power_active_out == 8'h00))
        else $error("standby did not clear registers");
    chk_supply_clear: assert property (
        $rose(predriver_supply_low_in) |-> ##[2:4]
        (spindle_level_out == 12'h000 && gain_high_out == 3'h0))
        else $error("supply low did not clear registers");
    chk_regulator_clear: assert property (
        $rose(internal_regulator_supply_low_in) |-> ##[2:4]
        (loading_level_out == 12'h000 && channel_enable_out == 8'h00))
        else $error("regulator low did not clear registers");
    chk_hot_summary: assert property (
        s_hot |-> fault_summary_out && channel_enable_out == 8'h00)
        else $error("overtemperature not reported");
    chk_limit_off: assert property (
        s_at_limit |-> !sled_on_out[0])
        else $error("sled stayed on at its limit");
    chk_spin_zone: assert property (
        spindle_level_out != 12'h000 |-> $signed(spindle_level_out) > 20
        || $signed(spindle_level_out) < -20)
        else $error("spindle driven inside dead zone");
    chk_sled_zone: assert property (
        sled_one_level_out != 10'h000 |-> $signed(sled_one_level_out) > 7
        || $signed(sled_one_level_out) < -7)
        else $error("sled driven inside dead zone");
endmodule : mdrv_regs_chk
bind mdrv_regs mdrv_regs_chk #(.WDT_LONG_CYC(WDT_LONG_CYC)) i_mdrv_regs_chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in),
    .predriver_supply_low_in(predriver_supply_low_in),
    .internal_regulator_supply_low_in(internal_regulator_supply_low_in),
    .standby_input_n_in(standby_input_n_in), .overtemp_in(overtemp_in),
    .pwm_clk_in(pwm_clk_in), .sled_limit_in(sled_limit_in),
    .focus_level_out(focus_level_out), .spindle_level_out(spindle_level_out),
    .loading_level_out(loading_level_out),
    .sled_one_level_out(sled_one_level_out), .sled_on_out(sled_on_out),
    .gain_high_out(gain_high_out), .channel_enable_out(channel_enable_out),
    .power_active_out(power_active_out),
    .fault_summary_out(fault_summary_out));

// ===== tb/mdrv_host.sv
// Host controller model that frames the serial link.
// Assumes the bench calls xfer only while the link is idle.
`timescale 1ns/100ps
module mdrv_host (
    // Link to the device.
    output logic sclk_out,
    output logic slv_n_out,
    output logic sdi_out,
    input logic sdo_in,
    input logic sdo_oe_in
);
    // The link clock stands still low between frames.
    initial begin
        sclk_out = 1'b0;
        slv_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Sends nbits of tx, MSB first; undriven read bits return unknown.
    task automatic xfer(input logic [15:0] tx, input int nbits,
        output logic [7:0] rx);
        slv_n_out = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi_out = tx[15 - i];
            #62.5 sclk_out = 1'b1;
            if (i > 7) rx = {rx[6:0], sdo_oe_in ? sdo_in : 1'bx};
            #62.5 sclk_out = 1'b0;
        end
        #62.5 slv_n_out = 1'b1;
    endtask : xfer
endmodule : mdrv_host

// ===== tb/tb_top.sv
// Self-checking bench for the motor driver register bank.
// Assumes a bound checker and the host model on the link.
`timescale 1ns/100ps
`include "mdrv_map.svh"
module tb_top;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [4:0] hz = 5'h00;
    logic ot = 1'b0, lshort = 1'b0, pwm = 1'b0;
    logic [1:0] lim = 2'h0;
    logic sclk, slv_n, sdi, sdo, sdo_oe, spb, lsb, summ;
    logic [11:0] fc, tk, sp, ld;
    logic [9:0] s1, s2;
    logic [1:0] son;
    logic [2:0] gain;
    logic [7:0] chen, pwr, rd;
    int err_total = 0;
    int compares = 0;
    logic [6:0] ra [7] = '{7'h70, 7'h72, 7'h74, 7'h76, 7'h77, 7'h7b, 7'h78};
    logic [7:0] mk [7] = '{8'h76, 8'h76, 8'h76, 8'h30, 8'h00, 8'hc0, 8'h00};
    logic [11:0] sv [10] = '{12'hfec, 12'h014, 12'h015, 12'hfeb, 12'h01c,
        12'h020, 12'hfe4, 12'hfe0, 12'h023, 12'h7ff};
    logic [9:0] lx [10] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
        10'h008, 10'h000, 10'h3f8, 10'h008, 10'h1ff};
    logic [7:0] cl [3] = '{8'h20, 8'h04, 8'h10};
    logic [7:0] ce [3] = '{8'h92, 8'h82, 8'h00};
    // The watchdog parameter is shortened so a timeout fits in the run.
    mdrv_regs #(.WDT_LONG_CYC(14'h1f4)) i_mdrv_regs (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk),
        .slv_n_in(slv_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
        .predriver_supply_low_in(hz[0]),
        .internal_regulator_supply_low_in(hz[1]),
        .standby_input_n_in(!hz[2]), .predriver_supply_deep_low_in(hz[3]),
        .internal_regulator_supply_deep_low_in(hz[4]),
        .overtemp_in(ot), .load_short_in(lshort), .pwm_clk_in(pwm),
        .sled_limit_in(lim), .focus_level_out(fc), .tracking_level_out(tk),
        .spindle_level_out(sp), .loading_level_out(ld),
        .sled_one_level_out(s1), .sled_two_level_out(s2), .sled_on_out(son),
        .gain_high_out(gain), .spindle_reverse_brake_out(spb),
        .load_short_brake_out(lsb), .channel_enable_out(chen),
        .power_active_out(pwr), .fault_summary_out(summ));
    mdrv_host i_mdrv_host (.sclk_out(sclk), .slv_n_out(slv_n),
        .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
    // Main clock.
    always #5 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    // Counts one comparison and reports a mismatch at once.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // Lets a frame reach the main domain, which takes four edges.
    task automatic gap();
        repeat (8) @(negedge clk_in);
    endtask : gap
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_mdrv_host.xfer({a, 1'b0, d}, 16, rd);
        gap();
    endtask : wr
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
        i_mdrv_host.xfer({a, 1'b1, 8'h00}, 16, rd);
        cmp(rd, e);
        gap();
    endtask : chk_rd
    task automatic setp(input logic [3:0] idx, input logic [11:0] d);
        i_mdrv_host.xfer({idx, d}, 16, rd);
        gap();
    endtask : setp
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // Watchdog well beyond the expected run time.
    initial begin
        #900000;
        err_total++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        repeat (20) @(negedge clk_in);
        rst_b_in = 1'b1;
        gap();
        foreach (ra[i]) chk_rd(ra[i], 8'h00);
        foreach (ra[i]) wr(ra[i], 8'hff);
        foreach (ra[i]) chk_rd(ra[i], mk[i]);
        cmp(gain, 12'h007);
        cmp({spb, lsb, chen, pwr}, 18'h37676);
        note("modes");
        foreach (sv[i]) begin
            setp(`MDRV_IDX_SPINDLE, sv[i]);
            setp(`MDRV_IDX_SLED_ONE, sv[i]);
            cmp(sp, i < 2 ? 12'h000 : sv[i]);
            cmp(s1, lx[i]);
        end
        setp(`MDRV_IDX_FOCUS, 12'h800);
        setp(`MDRV_IDX_TRACKING, 12'h7ff);
        setp(`MDRV_IDX_LOADING, 12'h801);
        setp(`MDRV_IDX_SLED_TWO, 12'h100);
        cmp(fc, 12'h800);
        cmp(tk, 12'h7ff);
        cmp(ld, 12'h801);
        cmp(s2, 12'h040);
        note("setpoints");
        pwm = 1'b1;
        gap();
        cmp(son, 12'h003);
        lim = 2'h1;
        gap();
        cmp(son, 12'h002);
        pwm = 1'b0;
        gap();
        lim = 2'h0;
        pwm = 1'b1;
        gap();
        cmp(son, 12'h003);
        pwm = 1'b0;
        note("sled pwm");
        wr(7'h75, 8'h80);
        cmp({fc, s1}, 12'h000);
        chk_rd(7'h7b, 8'h80);
        chk_rd(7'h70, 8'h76);
        chk_rd(7'h75, 8'h00);
        note("setpoint reset");
        i_mdrv_host.xfer(16'hffff, 15, rd);
        gap();
        lshort = 1'b1;
        gap();
        lshort = 1'b0;
        wr(7'h76, 8'h20);
        repeat (600) @(negedge clk_in);
        wr(7'h76, 8'h00);
        chk_rd(7'h77, 8'h96);
        cmp(chen, 12'h000);
        foreach (cl[i]) begin
            wr(7'h75, cl[i]);
            chk_rd(7'h77, ce[i]);
        end
        cmp({summ, chen}, 12'h076);
        note("latched flags");
        lshort = 1'b1;
        gap();
        lshort = 1'b0;
        setp(`MDRV_IDX_FOCUS, 12'h123);
        ot = 1'b1;
        gap();
        wr(7'h75, 8'h40);
        chk_rd(7'h77, 8'h88);
        foreach (ra[i]) chk_rd(ra[i], i == 4 ? 8'h88 : 8'h00);
        cmp({gain, fc}, 12'h123);
        ot = 1'b0;
        gap();
        chk_rd(7'h77, 8'h00);
        note("control reset");
        for (int i = 0; i < 5; i++) begin
            wr(7'h70, 8'h76);
            setp(`MDRV_IDX_FOCUS, 12'h123);
            hz = (5'h01 << i) | (5'h01 << (i % 3));
            gap();
            cmp({chen, fc}, 12'h000);
            hz = 5'h00;
            gap();
            chk_rd(7'h70, 8'h00);
            if (i == 0) begin
                wr(7'h75, 8'h40);
                chk_rd(7'h77, 8'h81);
            end
        end
        chk_rd(7'h77, 8'h00);
        note("hard resets");
        wrap_up();
    end
endmodule : tb_top
